/* File: hw/instruction_fetch_pipeline.sv */
/*
Fetch/execute pipeline control for an 8-bit core with 16-bit instruction words.
Assumes a synchronous program memory returning the word at prog_addr each cycle,
and one 20 MHz clock with a synchronous active-high reset.
*/
// Summary of operation
// RL1 - Divide clock by four into phases
// RL2 - Step PC in Q1, latch in Q4
// RL3 - Fetch overlaps execute of previous word
// RL4 - Instruction register loads Q1, executes Q2-Q4
// RL5 - Operand read Q2, destination write Q4
// RL6 - Flow changes flush prefetch, two cycles
// RL7 - Byte-addressed memory, words at even addresses
// RL8 - PC steps by two, bit zero zero
// RL9 - Absolute targets load PC bits 20:1
// RL10 - Relative offsets count words, scaled by two
// RL11 - Second words start 1111, 12-bit literal
// RL12 - Lone second word executes as no-op
// RL13 - Software computed offsets are even bytes
// RL14 - Return-with-literal returns and delivers literal
// RL15 - Table read uses pointer and data latch
// RL16 - Data memory uses 12-bit addresses
// RL17 - Sixteen banks of 256 bytes, all built
// RL18 - Unbuilt data locations read as zero
// RL19 - Fast-access bank maps low storage, controls
// RL20 - Bank selector gives upper four bits
// RL21 - Calls push PC, returns pop it
// RL22 - Reset restarts phases, pipeline empty
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pipe_regs.svh"
module instruction_fetch_pipeline
    import fetch_pipe_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [15:0] prog_word,
    input  wire logic [7:0]  prog_byte,
    output logic      [20:0] prog_addr,
    output logic      [20:0] table_addr,
    output logic      [15:0] instruction_register,
    output logic      [7:0]  working_register,
    output logic      [3:0]  bank_selector,
    output logic      [7:0]  table_data_latch,
    output logic      [20:0] table_byte_pointer,
    output logic      [7:0]  lookup_value,
    output logic             lookup_valid,
    output logic             prefetch_valid
);
    phase_t phase;
    logic [20:0] program_counter;
    logic [15:0] prefetch_word;
    logic        exec_valid;
    logic        second_pending;
    logic [15:0] first_word;
    logic [7:0]  operand;
    logic [4:0]  stack_ptr;
    logic [20:0] return_stack [1:`STACK_DEPTH];
    logic        table_pending;

    wire [7:0] dmem_rdata;

    phase_sequencer u_phase
    (
        .ref_clk (ref_clk),
        .rst     (rst),
        .phase   (phase)
    );

    wire q1 = (phase == phase_q1);
    wire q2 = (phase == phase_q2);
    wire q4 = (phase == phase_q4);

    // Decode of the word held in the instruction register.
    wire exec_live = exec_valid;
    wire [15:0] w = instruction_register;
    wire is_second = exec_live && (w[15:12] == `SECOND_WORD_TAG); // [RL11]
    wire lone_nop  = is_second && !second_pending; // [RL12]
    wire use_second = is_second && second_pending; // [RL12]
    wire is_goto1  = exec_live && (w[15:8] == `OP_GOTO);
    wire is_call1  = exec_live && (w[15:9] == `OP_CALL_HI);
    wire is_move1  = exec_live && (w[15:12] == `OP_MOVE_FILE);
    wire is_bra    = exec_live && (w[15:11] == `OP_BRA_HI);
    wire is_return = exec_live && (w == `OP_RETURN);
    wire is_lit_ret = exec_live && (w[15:8] == `OP_RETURN_LIT);
    wire is_movlb  = exec_live && (w[15:8] == `OP_MOVLB);
    wire is_movlw  = exec_live && (w[15:8] == `OP_MOVLW);
    wire is_add_low = exec_live && (w == `OP_ADD_PC_LOW);
    wire is_tblrd  = exec_live && (w == `OP_TBLRD);
    wire first_of_two = is_goto1 || is_call1 || is_move1;
    wire first_abs    = first_word[15:8] == `OP_GOTO || first_word[15:9] == `OP_CALL_HI;
    wire first_call   = first_word[15:9] == `OP_CALL_HI;
    wire first_move   = first_word[15:12] == `OP_MOVE_FILE;

    // Program flow targets; prog_addr holds the address after the executing word.
    wire [20:0] abs_target = {w[11:0], first_word[7:0], 1'b0}; // [RL9]
    wire [20:0] rel_offset = {{9{w[10]}}, w[10:0], 1'b0}; // [RL10]
    wire [20:0] bra_target = prog_addr + rel_offset;
    wire [20:0] pcl_target = {prog_addr[20:8],
                              8'(prog_addr[7:0] + working_register)}; // [RL13]
    wire [20:0] pop_target = (stack_ptr == 5'd0) ? `PC_RESET : return_stack[stack_ptr];
    wire abs_jump  = use_second && first_abs;
    wire pop_jump  = is_return || is_lit_ret;
    wire flow_change = abs_jump || is_bra || pop_jump || is_add_low; // [RL6]
    wire [20:0] flow_target = abs_jump ? abs_target :
                              is_bra   ? bra_target :
                              pop_jump ? pop_target : pcl_target;

    // Data address: fast-access bank or banked, full 12 bits for the file move.
    wire access_bit = w[8];
    wire [7:0] low_addr = w[7:0];
    wire [3:0] access_bank = (low_addr < `ACCESS_SPLIT) ? 4'h0 : `ACCESS_HIGH_BANK; // [RL19]
    wire [3:0] bank_part = access_bit ? bank_selector : access_bank; // [RL20]
    wire [11:0] dmem_addr = use_second && first_move ? w[11:0] :
                            is_move1 ? w[11:0] : {bank_part, low_addr}; // [RL16]
    wire dmem_we = q4 && use_second && first_move; // [RL5]

    data_space u_data
    (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .addr       (dmem_addr),
        .write_en   (dmem_we),
        .write_data (operand),
        .read_data  (dmem_rdata)
    );

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            program_counter <= `PC_RESET;
            prog_addr       <= `PC_RESET;
            prefetch_word   <= 16'h0000;
            prefetch_valid  <= 1'b0; // [RL22]
            instruction_register <= 16'h0000;
            exec_valid      <= 1'b0;
        end
        else if (q1)
        begin
            instruction_register <= prefetch_word; // [RL4] [RL3]
            exec_valid      <= prefetch_valid;
            prog_addr       <= {program_counter[20:1], 1'b0}; // [RL7]
            program_counter <= program_counter + `WORD_STEP; // [RL2]
        end
        else if (q4)
        begin
            prefetch_word  <= prog_word; // [RL2]
            prefetch_valid <= !flow_change; // [RL6]
            if (flow_change)
                program_counter <= {flow_target[20:1], 1'b0}; // [RL8]
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            second_pending <= 1'b0;
            first_word     <= 16'h0000;
            operand        <= 8'h00;
        end
        else if (q2)
        begin
            if (is_move1)
                operand <= dmem_rdata; // [RL5]
        end
        else if (q4)
        begin
            second_pending <= first_of_two; // [RL11]
            if (first_of_two)
                first_word <= w;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            stack_ptr <= 5'd0;
            working_register <= 8'h00;
            bank_selector <= 4'h0;
            lookup_value <= 8'h00;
            lookup_valid <= 1'b0;
        end
        else
        begin
            lookup_valid <= q4 && is_lit_ret; // [RL14]
            if (q4)
            begin
                if (is_lit_ret)
                begin
                    lookup_value <= w[7:0]; // [RL14]
                    working_register <= w[7:0];
                end
                if (is_movlw)
                    working_register <= w[7:0];
                if (is_movlb)
                    bank_selector <= w[3:0]; // [RL20]
                if (abs_jump && first_call && stack_ptr < 5'(`STACK_DEPTH))
                begin
                    stack_ptr <= stack_ptr + 5'd1; // [RL21]
                    return_stack[stack_ptr + 5'd1] <= prog_addr;
                end
                else if (pop_jump && stack_ptr != 5'd0)
                    stack_ptr <= stack_ptr - 5'd1; // [RL21]
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            table_byte_pointer <= 21'h00_0000;
            table_addr <= 21'h00_0000;
            table_data_latch <= 8'h00;
            table_pending <= 1'b0;
        end
        else if (q4)
        begin
            table_pending <= is_tblrd;
            if (is_tblrd)
                table_addr <= table_byte_pointer; // [RL15]
            if (table_pending)
                table_data_latch <= prog_byte; // [RL15]
            if (dmem_we && w[11:0] == 12'hFF6)
                table_byte_pointer <= {table_byte_pointer[20:8], operand};
        end
    end

    sequence s_fetch_then_exec;
        (phase == phase_q4) ##1 (phase == phase_q1);
    endsequence
    property p_ir_loads_prefetch;
        @(posedge ref_clk) disable iff (rst)
        s_fetch_then_exec |=> (instruction_register == $past(prefetch_word));
    endproperty
    a_ir_loads_prefetch: assert property (p_ir_loads_prefetch) else $error("ir not loaded"); // [RL4]
    property p_pc_even;
        @(posedge ref_clk) disable iff (rst) program_counter[0] == 1'b0;
    endproperty
    a_pc_even: assert property (p_pc_even) else $error("pc odd"); // [RL8]
    property p_pc_step;
        @(posedge ref_clk) disable iff (rst)
        (q1) |=> (program_counter == $past(program_counter) + `WORD_STEP);
    endproperty
    a_pc_step: assert property (p_pc_step) else $error("pc step wrong"); // [RL2]
    property p_flush;
        @(posedge ref_clk) disable iff (rst)
        (q4 && flow_change) |=> !prefetch_valid ##3 !exec_valid;
    endproperty
    a_flush: assert property (p_flush) else $error("no flush"); // [RL6]
    property p_lone_nop_no_write;
        @(posedge ref_clk) disable iff (rst) lone_nop |-> !dmem_we;
    endproperty
    a_lone_nop_no_write: assert property (p_lone_nop_no_write) else $error("nop wrote"); // [RL12]
    property p_write_q4;
        @(posedge ref_clk) disable iff (rst) dmem_we |-> q4;
    endproperty
    a_write_q4: assert property (p_write_q4) else $error("write not in q4"); // [RL5]
    property p_literal_value;
        @(posedge ref_clk) disable iff (rst)
        (q4 && is_lit_ret) |=> lookup_valid && lookup_value == $past(w[7:0]);
    endproperty
    a_literal_value: assert property (p_literal_value) else $error("literal lost"); // [RL14]
    property p_reset_empty;
        @(posedge ref_clk) rst |=> !prefetch_valid && phase == phase_q1;
    endproperty
    a_reset_empty: assert property (p_reset_empty) else $error("reset state wrong"); // [RL22]
    property p_prog_addr_even;
        @(posedge ref_clk) disable iff (rst) prog_addr[0] == 1'b0;
    endproperty
    a_prog_addr_even: assert property (p_prog_addr_even) else $error("odd fetch"); // [RL7]

    // Branch, jump, refetch and lookup pulse checks.
    sequence s_branch_exec;
        q4 && is_bra;
    endsequence
    property p_branch_target;
        @(posedge ref_clk) disable iff (rst)
        s_branch_exec |=> program_counter ==
            $past(prog_addr) + {{9{$past(w[10])}}, $past(w[10:0]), 1'b0};
    endproperty
    a_branch_target: assert property (p_branch_target) else $error("bad branch"); // [RL10]
    sequence s_abs_exec;
        q4 && abs_jump;
    endsequence
    property p_abs_target;
        @(posedge ref_clk) disable iff (rst)
        s_abs_exec |=> program_counter == {$past(w[11:0]), $past(first_word[7:0]), 1'b0};
    endproperty
    a_abs_target: assert property (p_abs_target) else $error("bad jump"); // [RL9]
    sequence s_flush_edge;
        (q4 && flow_change) ##1 q1;
    endsequence
    property p_flush_refetch;
        @(posedge ref_clk) disable iff (rst)
        s_flush_edge |=> prog_addr == $past(program_counter);
    endproperty
    a_flush_refetch: assert property (p_flush_refetch) else $error("no refetch"); // [RL6]
    property p_lookup_pulse;
        @(posedge ref_clk) disable iff (rst) lookup_valid |=> !lookup_valid;
    endproperty
    a_lookup_pulse: assert property (p_lookup_pulse) else $error("long pulse"); // [RL14]

    // Phase placement of the pipeline registers.
    property p_prefetch_hold;
        @(posedge ref_clk) disable iff (rst) !q4 |=> $stable(prefetch_word);
    endproperty
    a_prefetch_hold: assert property (p_prefetch_hold) else $error("prefetch moved"); // [RL2]
    property p_exec_hold;
        @(posedge ref_clk) disable iff (rst) !q1 |=> $stable(instruction_register);
    endproperty
    a_exec_hold: assert property (p_exec_hold) else $error("word moved"); // [RL4]
    property p_fetch_hold;
        @(posedge ref_clk) disable iff (rst) !q1 |=> $stable(prog_addr);
    endproperty
    a_fetch_hold: assert property (p_fetch_hold) else $error("fetch moved"); // [RL2]
    property p_operand_q2;
        @(posedge ref_clk) disable iff (rst) !q2 |=> $stable(operand);
    endproperty
    a_operand_q2: assert property (p_operand_q2) else $error("operand moved"); // [RL5]
    property p_bank_load;
        @(posedge ref_clk) disable iff (rst)
        (q4 && is_movlb) |=> bank_selector == $past(w[3:0]);
    endproperty
    a_bank_load: assert property (p_bank_load) else $error("bank lost"); // [RL20]
    property p_second_held;
        @(posedge ref_clk) disable iff (rst)
        (q4 && first_of_two) |=> second_pending && first_word == $past(w);
    endproperty
    a_second_held: assert property (p_second_held) else $error("first word lost"); // [RL11]

    // Return stack checks.
    sequence s_call_push;
        q4 && abs_jump && first_call && stack_ptr < 5'(`STACK_DEPTH);
    endsequence
    property p_push;
        @(posedge ref_clk) disable iff (rst)
        s_call_push |=> stack_ptr == $past(stack_ptr) + 5'd1
            && return_stack[stack_ptr] == $past(prog_addr);
    endproperty
    a_push: assert property (p_push) else $error("push wrong"); // [RL21]
    property p_pop;
        @(posedge ref_clk) disable iff (rst)
        (q4 && pop_jump && stack_ptr != 5'd0) |=> stack_ptr == $past(stack_ptr) - 5'd1;
    endproperty
    a_pop: assert property (p_pop) else $error("pop wrong"); // [RL21]
    property p_underflow;
        @(posedge ref_clk) disable iff (rst)
        (q4 && pop_jump && stack_ptr == 5'd0) |=> program_counter == `PC_RESET;
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow target"); // [RL21]

    // Table read checks.
    sequence s_table_read;
        (q4 && is_tblrd) ##4 q4;
    endsequence
    property p_table_latch;
        @(posedge ref_clk) disable iff (rst)
        s_table_read |=> table_data_latch == $past(prog_byte);
    endproperty
    a_table_latch: assert property (p_table_latch) else $error("latch wrong"); // [RL15]
    property p_table_addr;
        @(posedge ref_clk) disable iff (rst)
        (q4 && is_tblrd) |=> table_addr == $past(table_byte_pointer);
    endproperty
    a_table_addr: assert property (p_table_addr) else $error("table addr wrong"); // [RL15]
endmodule : instruction_fetch_pipeline
`default_nettype wire

/* File: hw/fetch_pipe_regs.svh */
/*
Constants for the fetch pipeline: widths, field positions and opcode codes.
Assumes inclusion by its bare name from the design files.
*/
`ifndef FETCH_PIPE_REGS_SVH
`define FETCH_PIPE_REGS_SVH
`define PC_WIDTH         21
`define PC_RESET         21'h00_0000
`define WORD_STEP        21'h00_0002
`define DATA_ADDR_WIDTH  12
`define BANK_COUNT       16
`define BANK_BYTES       256
`define ACCESS_SPLIT     8'h80
`define ACCESS_HIGH_BANK 4'hF
`define SECOND_WORD_TAG  4'hF
`define OP_GOTO          8'hEF
`define OP_CALL_HI       7'h76
`define OP_BRA_HI        5'h1A
`define OP_RETURN        16'h0012
`define OP_RETURN_LIT    8'h0C
`define OP_MOVLB         8'h01
`define OP_MOVE_FILE     4'hC
`define OP_ADD_PC_LOW    16'h26F9
`define OP_MOVLW         8'h0E
`define OP_TBLRD         16'h0008
`define STACK_DEPTH      31
`endif

/* File: hw/fetch_pipe_pkg.sv */
/*
Types shared by the fetch pipeline modules.
Assumes nothing of its surroundings.
*/
package fetch_pipe_pkg;
    typedef enum logic [1:0] {phase_q1, phase_q2, phase_q3, phase_q4} phase_t;
endpackage : fetch_pipe_pkg

/* File: hw/phase_sequencer.sv */
/*
Four-phase sequencer dividing the core clock by four.
Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module phase_sequencer
    import fetch_pipe_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic rst,
    output var  phase_t phase
);
    phase_t next_phase;

    always_comb
    begin
        case (phase)
            phase_q1: next_phase = phase_q2;
            phase_q2: next_phase = phase_q3;
            phase_q3: next_phase = phase_q4;
            phase_q4: next_phase = phase_q1;
            default:  next_phase = phase_q1;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
            phase <= phase_q1; // [RL22]
        else
            phase <= next_phase; // [RL1]
    end

    property p_phase_order;
        @(posedge ref_clk) disable iff (rst)
        (phase == phase_q1) |=> (phase == phase_q2) ##1 (phase == phase_q3)
            ##1 (phase == phase_q4) ##1 (phase == phase_q1);
    endproperty
    a_phase_order: assert property (p_phase_order) else $error("phase order broken"); // [RL1]
endmodule : phase_sequencer
`default_nettype wire

/* File: hw/data_space.sv */
/*
Banked data memory with built-bank decoding and zero reads.
Assumes reads and writes come from the core in Q2 and Q4.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fetch_pipe_regs.svh"
module data_space
    import fetch_pipe_pkg::*;
#(
    parameter int unsigned BANKS_BUILT = `BANK_COUNT
)
(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [11:0] addr,
    input  wire logic        write_en,
    input  wire logic [7:0]  write_data,
    output logic      [7:0]  read_data
);
    logic [7:0] storage [0:`BANK_COUNT*`BANK_BYTES-1];
    wire        built = ({28'h000_0000, addr[11:8]} < BANKS_BUILT);

    always_ff @(posedge ref_clk)
    begin
        if (write_en && built)
            storage[addr] <= write_data; // [RL16] [RL17]
    end

    assign read_data = built ? storage[addr] : 8'h00; // [RL18]
endmodule : data_space
`default_nettype wire

/* File: verif/prog_memory_model.sv */
/*
Program memory model: word array with synchronous word and byte reads.
Assumes the bench loads the words while reset is held.
*/
`timescale 1ns/1ps
`default_nettype none
module prog_memory_model
(
    input  wire logic        ref_clk,
    input  wire logic [20:0] prog_addr,
    input  wire logic [20:0] table_addr,
    output var  logic [15:0] prog_word,
    output var  logic [7:0]  prog_byte
);
    logic [15:0] words [0:255];
    wire  logic [15:0] table_word = words[table_addr[8:1]];

    always_ff @(posedge ref_clk)
    begin
        prog_word <= words[prog_addr[8:1]];
        prog_byte <= table_addr[0] ? table_word[15:8] : table_word[7:0];
    end
endmodule : prog_memory_model
`default_nettype wire

/* File: verif/instruction_fetch_pipeline_tb.sv */
/*
Self-checking bench for the fetch pipeline with a look-up table program.
Assumes the program memory model answers every fetch.
*/
`timescale 1ns/1ps
`default_nettype none
module instruction_fetch_pipeline_tb;
    logic        ref_clk;
    logic        rst;
    logic [15:0] prog_word;
    logic [7:0]  prog_byte;
    logic [20:0] prog_addr;
    logic [20:0] table_addr;
    logic [7:0]  working_register;
    logic [3:0]  bank_selector;
    logic [7:0]  table_data_latch;
    logic [7:0]  lookup_value;
    logic        lookup_valid;
    logic        prefetch_valid;
    int          n_fail = 0;
    int          samples_checked = 0;
    int          cyc;
    int          last_cyc;
    int          pulses;
    logic [20:0] last_addr;
    logic [31:0] seed = 32'h680e_bc9c;
    logic [7:0]  lit [0:2];
    logic [7:0]  off;
    logic [3:0]  bank;

    instruction_fetch_pipeline dut_u (
        .ref_clk(ref_clk), .rst(rst), .prog_word(prog_word), .prog_byte(prog_byte),
        .prog_addr(prog_addr), .table_addr(table_addr), .instruction_register(),
        .working_register(working_register), .bank_selector(bank_selector),
        .table_data_latch(table_data_latch), .table_byte_pointer(),
        .lookup_value(lookup_value), .lookup_valid(lookup_valid),
        .prefetch_valid(prefetch_valid));

    prog_memory_model mem_u (
        .ref_clk(ref_clk), .prog_addr(prog_addr), .table_addr(table_addr),
        .prog_word(prog_word), .prog_byte(prog_byte));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic finish_test;
        if (n_fail == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    // The even byte offset selects the table entry it lands on.
    function automatic logic [7:0] table_entry(input logic [7:0] byte_off);
        return lit[byte_off >> 1];
    endfunction : table_entry

    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk)
    begin
        if (rst)
        begin
            cyc = 0;
            last_cyc = -1;
            pulses = 0;
            last_addr = '0;
        end
        else
        begin
            cyc++;
            check("prog_addr bit 0", prog_addr[0], 1'b0);
            if (prog_addr !== last_addr)
            begin
                if (last_cyc >= 0)
                    check("fetch spacing", (cyc - last_cyc) % 4, 0);
                last_cyc = cyc;
                last_addr = prog_addr;
            end
            if (lookup_valid === 1'b1)
                pulses++;
        end
    end

    initial
    begin
        rst = 1'b1;
        for (int i = 0; i < 256; i++)
            mem_u.words[i] = 16'h0000;
        for (int run = 0; run < 3; run++)
        begin
            @(posedge ref_clk);
            #5 rst = 1'b1;
            seed = xorshift(seed);
            lit[0] = seed[7:0];
            lit[1] = seed[15:8];
            lit[2] = seed[23:16];
            bank = seed[27:24];
            off = 8'(2 * run);
            mem_u.words[0] = 16'h0008;
            mem_u.words[1] = {8'h0E, off};
            mem_u.words[2] = 16'hEC10;
            mem_u.words[3] = 16'hF000;
            mem_u.words[4] = {12'h010, bank};
            mem_u.words[5] = 16'hEF0A;
            mem_u.words[6] = 16'hF000;
            mem_u.words[7] = 16'h0E11;
            mem_u.words[10] = 16'hF0FF;
            mem_u.words[11] = 16'hD001;
            mem_u.words[12] = 16'h0E22;
            mem_u.words[13] = 16'hD7FF;
            mem_u.words[16] = 16'h26F9;
            for (int i = 0; i < 3; i++)
                mem_u.words[17 + i] = {8'h0C, lit[i]};
            repeat (2) @(posedge ref_clk);
            #5 rst = 1'b0;
            check("prefetch_valid after reset", prefetch_valid, 1'b0);
            check("prog_addr after reset", prog_addr, 21'h0);
            repeat (240) @(posedge ref_clk);
            #5;
            check("working_register", working_register, table_entry(off));
            check("lookup_value", lookup_value, table_entry(off));
            check("lookup pulses", pulses, 1);
            check("bank_selector", bank_selector, bank);
            check("table_data_latch", table_data_latch, 8'h08);
            check("table_addr", table_addr, 21'h0);
        end
        finish_test();
    end

    initial
    begin
        #(3 * 260 * 50 * 2);
        n_fail++;
        finish_test();
    end
endmodule : instruction_fetch_pipeline_tb
`default_nettype wire
